// ==== core/adc_seq.sv ====
// Conversion sequencer and parallel result port of a simultaneous-sampling
// converter. Assumes the analog core presents every channel's code on
// sample_in in the mclk domain; host pins are asynchronous to mclk.
module adc_seq
  import adc_seq_pkg::*;
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // Host pins and analog codes.
  input wire host_pins_t pins,
  input wire sample_set_t sample_in,
  // Parallel result bus.
  output logic [RES_W-1:0] data_out,
  output logic data_oe,
  // Status strobes.
  output logic result_ready_n,
  output logic last_result_ready_n,
  // Analog control.
  output logic track_hold,
  output logic analog_power,
  output logic [N_CH-1:0] channel_power
);

  typedef struct packed {
    host_pins_t s1;
    host_pins_t s2;
    host_pins_t s3;
    host_pins_t lvl;
    seq_state_t state;
    logic [CFG_W-1:0] cfg;
    logic [CFG_W-1:0] active;
    sample_set_t held;
    logic [1:0] div;
    logic [5:0] ticks;
    logic [5:0] due;
    logic [3:0] done;
    logic [2:0] rd_idx;
    logic [RES_W-1:0] data_out;
    logic data_oe;
    logic result_ready_n;
    logic last_result_ready_n;
    logic track_hold;
    logic analog_power;
    logic [N_CH-1:0] channel_power;
  } seq_regs_t;

  localparam seq_regs_t REGS_RESET = '{
    s1: PINS_RESET, s2: PINS_RESET, s3: PINS_RESET, lvl: PINS_RESET,
    state: ST_TRACK, cfg: CFG_RESET, active: CFG_RESET, held: '0,
    div: 2'h0, ticks: 6'h00, due: FIRST_TICK, done: 4'h0, rd_idx: 3'h0,
    data_out: 12'h000, data_oe: 1'b0, result_ready_n: 1'b1,
    last_result_ready_n: 1'b1, track_hold: 1'b0, analog_power: 1'b1,
    channel_power: POWER_ALL};

  // Number of set bits in an enable mask.
  function automatic logic [3:0] count_ones(input logic [CFG_W-1:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < CFG_W; i++) begin
      c = c + {3'h0, m[i]};
    end
    return c;
  endfunction : count_ones

  // Channel index of the idx-th enabled channel, counting upward.
  function automatic logic [2:0] nth_enabled(input logic [CFG_W-1:0] m,
                                             input logic [3:0] idx);
    logic [3:0] seen;
    logic [2:0] ch;
    seen = 4'h0;
    ch = 3'h0;
    for (int i = 0; i < CFG_W; i++) begin
      if (m[i]) begin
        if (seen == idx) begin
          ch = 3'(i);
        end
        seen = seen + 4'h1;
      end
    end
    return ch;
  endfunction : nth_enabled

  seq_regs_t q;
  seq_regs_t d;

  always_comb begin
    host_pins_t f;
    host_pins_t o;
    logic start_rise;
    logic start_fall;
    logic pd_fall;
    logic tick;
    logic [3:0] n_en;
    logic [5:0] ticks_nx;
    logic begin_conv;
    f = q.lvl;
    o = q.lvl;
    start_rise = 1'b0;
    start_fall = 1'b0;
    pd_fall = 1'b0;
    tick = 1'b0;
    n_en = 4'h0;
    ticks_nx = 6'h00;
    begin_conv = 1'b0;
    d = q;

    // Three-stage capture; a level is accepted once stages two and three
    // agree, so a pin caught mid-transition never produces a false edge.
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int b = 0; b < $bits(host_pins_t); b++) begin
      if (q.s2[b] == q.s3[b]) begin
        f[b] = q.s3[b];
      end
    end
    d.lvl = f;

    start_rise = f.sample_start_strobe & ~o.sample_start_strobe;
    start_fall = ~f.sample_start_strobe & o.sample_start_strobe;
    pd_fall = ~f.full_power_down & o.full_power_down;
    n_en = count_ones(q.active);

    // Conversion tick: divided mclk or rising edge of the host clock.
    if (f.clock_source_select) begin
      d.div = (q.div == INT_DIV_LAST) ? 2'h0 : q.div + 2'h1;
      tick = (q.div == INT_DIV_LAST);
    end else begin
      d.div = 2'h0;
      tick = f.ext_conv_clk & ~o.ext_conv_clk;
    end

    // Enable byte is latched when the write strobe rises under select.
    if (f.wr_n & ~o.wr_n & ~f.cs_n) begin
      d.cfg = f.data_in;
    end

    // Ready pulse lasts one cycle unless set below.
    d.result_ready_n = 1'b1;

    if (f.full_power_down) begin
      d.state = ST_OFF;
      d.result_ready_n = 1'b1;
      d.last_result_ready_n = 1'b1;
      d.track_hold = 1'b0;
    end else begin
      case (q.state)
        ST_OFF: begin
          d.state = ST_TRACK;
          begin_conv = pd_fall;
        end
        ST_TRACK: begin
          d.track_hold = 1'b0;
          begin_conv = start_rise;
        end
        ST_CONV: begin
          if (start_fall) begin
            d.state = ST_TRACK;
            d.track_hold = 1'b0;
          end else if (tick) begin
            ticks_nx = q.ticks + 6'h01;
            d.ticks = ticks_nx;
            if (ticks_nx == q.due) begin
              d.due = q.due + NEXT_TICKS;
              d.done = q.done + 4'h1;
              d.result_ready_n = 1'b0;
              if (q.done + 4'h1 == n_en) begin
                d.last_result_ready_n = 1'b0;
                d.state = ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          if (start_fall) begin
            d.state = ST_TRACK;
            d.track_hold = 1'b0;
          end
        end
        default: begin
          d.state = ST_TRACK;
        end
      endcase
      // Strobe low starts a fresh acquisition with the latest enables.
      if (start_fall) begin
        d.active = d.cfg;
        d.last_result_ready_n = 1'b1;
        d.rd_idx = 3'h0;
      end
      // An empty enable mask has nothing to convert, so the start is ignored.
      if (begin_conv && count_ones(d.active) != 4'h0) begin
        d.state = ST_CONV;
        d.track_hold = 1'b1;
        d.held = sample_in;
        d.ticks = 6'h00;
        d.due = FIRST_TICK;
        d.done = 4'h0;
        d.rd_idx = 3'h0;
        d.last_result_ready_n = 1'b1;
      end
    end

    // Read port: drivers follow select and read only, never power-down.
    d.data_oe = ~f.cs_n & ~f.rd_n;
    if (~f.cs_n & ~f.rd_n) begin
      d.data_out = q.held[nth_enabled(q.active, {1'b0, q.rd_idx})];
    end
    if (f.rd_n & ~o.rd_n & ~o.cs_n) begin
      if ({1'b0, q.rd_idx} + 4'h1 >= n_en) begin
        d.rd_idx = 3'h0;
      end else begin
        d.rd_idx = q.rd_idx + 3'h1;
      end
    end

    // Power control: full power-down wins over idle power-down.
    d.analog_power = ~f.full_power_down;
    if (f.full_power_down) begin
      d.channel_power = '0;
    end else if (f.idle_channel_powerdown_n) begin
      d.channel_power = POWER_ALL;
    end else begin
      d.channel_power = d.cfg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= REGS_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign data_out = q.data_out;
  assign data_oe = q.data_oe;
  assign result_ready_n = q.result_ready_n;
  assign last_result_ready_n = q.last_result_ready_n;
  assign track_hold = q.track_hold;
  assign analog_power = q.analog_power;
  assign channel_power = q.channel_power;

endmodule : adc_seq

// ==== core/adc_seq_pkg.sv ====
// Constants, pin bundle and state types for the conversion sequencer.
// Assumes a single 40 MHz clock; every host pin arrives asynchronously.
//
// Summary of operation
// - Internal clock: hold and convert on strobe rise.
// - Pulse result ready low per available result.
// - Drive last-result ready low after final channel.
// - External clock: first result at 13th edge.
// - External clock: later results every three edges.
// - Internal clock: first result within 900ns.
// - Internal clock: later results within 225ns each.
// - Strobe fall mid-conversion aborts and restarts.
// - Chip select and read low drive result.
// - Reads after completion step through results, wrapping.
// - Power-up enables every channel.
// - Power-down overrides idle power-down, keeps enables.
// - Shutdown holds both ready outputs high.
// - Bus drivers follow chip select and read only.
// - Power-down fall starts a conversion like strobe.
// - Idle power-down low unpowers disabled channels.
// - Enable byte latched on write strobe rise.
// - New enable byte applies at next strobe fall.
package adc_seq_pkg;

  localparam int N_CH = 8;
  localparam int RES_W = 12;
  localparam int CFG_W = 8;

  // Timing, in the printed units and in clock cycles.
  localparam int CLK_PERIOD_NS = 25;
  localparam int FIRST_RESULT_NS = 900;
  localparam int NEXT_RESULT_NS = 225;
  localparam int FIRST_RESULT_CYC = FIRST_RESULT_NS / CLK_PERIOD_NS;
  localparam int NEXT_RESULT_CYC = NEXT_RESULT_NS / CLK_PERIOD_NS;
  localparam logic [5:0] FIRST_TICK = 6'h0d;
  localparam logic [5:0] NEXT_TICKS = 6'h03;
  // Internal conversion tick period, chosen so both bounds hold with margin.
  localparam int INT_DIV = FIRST_RESULT_CYC / (FIRST_TICK + NEXT_TICKS);
  localparam logic [1:0] INT_DIV_LAST = 2'(INT_DIV - 1);

  // Reset values.
  localparam logic [CFG_W-1:0] CFG_RESET = 8'hff;
  localparam logic [N_CH-1:0] POWER_ALL = 8'hff;

  // Host pin bundle; active-low strobes carry _n, except sample_start_strobe.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic sample_start_strobe;
    logic full_power_down;
    logic idle_channel_powerdown_n;
    logic clock_source_select;
    logic ext_conv_clk;
    logic [CFG_W-1:0] data_in;
  } host_pins_t;

  localparam host_pins_t PINS_RESET = '{
    cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sample_start_strobe: 1'b1,
    full_power_down: 1'b0, idle_channel_powerdown_n: 1'b1,
    clock_source_select: 1'b1, ext_conv_clk: 1'b0, data_in: 8'h00};

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11,
    ST_OFF = 2'b10
  } seq_state_t;

  typedef logic [N_CH-1:0][RES_W-1:0] sample_set_t;

endpackage : adc_seq_pkg

// ==== testbench/adc_seq_assertions.sv ====
// Port checks for the conversion sequencer.
// Assumes host pins hold each level long enough to pass the synchronisers.
module adc_seq_assertions
  import adc_seq_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Watched ports.
  input wire host_pins_t pins,
  input wire logic data_oe,
  input wire logic result_ready_n,
  input wire logic last_result_ready_n,
  input wire logic track_hold,
  input wire logic analog_power,
  input wire logic [N_CH-1:0] channel_power
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_down; pins.full_power_down [*5]; endsequence
  sequence s_read; (!pins.cs_n && !pins.rd_n) [*6]; endsequence
  sequence s_idle; (pins.cs_n || pins.rd_n) [*6]; endsequence
  sequence s_start; $rose(track_hold) && pins.clock_source_select; endsequence
  sequence s_next;
    $fell(result_ready_n) && last_result_ready_n && pins.clock_source_select;
  endsequence
  chk_ready_pulse: assert property (
    $fell(result_ready_n) |=> result_ready_n)
    else $error("ready pulse too long");
  chk_last_ready: assert property (
    $fell(last_result_ready_n) |-> !result_ready_n)
    else $error("last flag without result");
  chk_down_ready: assert property (
    s_down |-> result_ready_n && last_result_ready_n)
    else $error("ready low in shutdown");
  chk_down_power: assert property (
    s_down |-> !analog_power && channel_power == '0)
    else $error("powered in shutdown");
  chk_bus_drive: assert property (
    s_read |-> data_oe)
    else $error("bus not driven");
  chk_bus_float: assert property (
    s_idle |-> !data_oe)
    else $error("bus not released");
  chk_first_result: assert property (
    s_start |-> ##[1:36] (!result_ready_n || !track_hold))
    else $error("first result late");
  chk_next_result: assert property (
    s_next |-> ##[1:9] ($fell(result_ready_n) || !track_hold))
    else $error("next result late");
endmodule : adc_seq_assertions

bind adc_seq adc_seq_assertions chk_u (.mclk, .rst, .pins, .data_oe,
  .result_ready_n, .last_result_ready_n, .track_hold, .analog_power,
  .channel_power);

// ==== testbench/adc_host_clock.sv ====
// Host conversion clock for external clock mode.
// Assumes run rises with the start strobe and falls after the last result.
module adc_host_clock (
  // Clock and frame control.
  input wire logic mclk,
  input wire logic run,
  // Conversion clock and its count of rising edges.
  output logic ext_conv_clk,
  output logic [7:0] rises
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div;
  // Period of 8 mclk cycles; stands still low outside a frame.
  always @(posedge mclk) begin
    if (!run) begin
      div <= 2'h0;
      ext_conv_clk <= 1'b0;
      rises <= 8'h00;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        ext_conv_clk <= ~ext_conv_clk;
        rises <= rises + 8'(!ext_conv_clk);
      end
    end
  end
endmodule : adc_host_clock

// ==== testbench/test_adc_seq.sv ====
// Self-checking bench for the conversion sequencer.
// Assumes the host clock model and the bound checker are compiled first.
module test_adc_seq;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_seq_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic data_oe, rdy_n, last_n, ext_clk;
  logic hold, apwr;
  // Power-up wake time of 1 ms in mclk cycles.
  localparam int WAKE_CYC = 40000;
  logic [RES_W-1:0] data_out;
  logic [N_CH-1:0] channel_power;
  logic [7:0] rises, m;
  host_pins_t p, pv;
  sample_set_t smp;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'ha8c43c9a;
  always #12.5 mclk = ~mclk;
  always_comb begin
    pv = p;
    pv.ext_conv_clk = ext_clk;
  end
  adc_seq dut_u (.mclk(mclk), .rst(rst), .clk_en(1'b1), .pins(pv),
    .sample_in(smp), .data_out(data_out), .data_oe(data_oe),
    .result_ready_n(rdy_n), .last_result_ready_n(last_n), .track_hold(hold),
    .analog_power(apwr), .channel_power(channel_power));
  adc_host_clock host_u (.mclk(mclk), .run(run), .ext_conv_clk(ext_clk),
    .rises(rises));
  task automatic check(logic ok, string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic summarize;
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // Host clock rises counted when the n-th result is announced.
  function automatic logic [7:0] rise_due(int n);
    return 8'(FIRST_TICK + NEXT_TICKS * n);
  endfunction : rise_due
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick
  task automatic write_cfg(logic [7:0] v);
    p.cs_n = 1'b0;
    p.wr_n = 1'b0;
    p.data_in = v;
    tick(5);
    p.wr_n = 1'b1;
    tick(5);
    p.cs_n = 1'b1;
    p.data_in = ~v;
    tick(5);
  endtask : write_cfg
  task automatic convert(logic [7:0] v, logic ext, logic pd);
    int n;
    n = 0;
    p.clock_source_select = !ext;
    if (pd) p.full_power_down = 1'b0;
    else begin
      p.sample_start_strobe = 1'b0;
      tick(6);
      p.sample_start_strobe = 1'b1;
    end
    run = ext;
    for (int i = 0; i < 600 && last_n === 1'b1; i++) begin
      tick(1);
      if (rdy_n === 1'b0) begin
        if (ext) check(rises === rise_due(n), "clock count");
        n++;
      end
    end
    run = 1'b0;
    check(n == $countones(v) && last_n === 1'b0, "results");
  endtask : convert
  task automatic read_all(logic [7:0] v, logic follow);
    int k;
    k = 0;
    for (int r = 0; r <= $countones(v); r++) begin
      while (!v[k]) k = (k + 1) % N_CH;
      p.cs_n = 1'b0;
      p.rd_n = 1'b0;
      tick(6);
      check(data_oe === 1'b1 && data_out === smp[k], "read");
      p.rd_n = 1'b1;
      p.cs_n = follow;
      tick(6);
      check(data_oe === 1'b0, "release");
      k = (k + 1) % N_CH;
    end
  endtask : read_all
  initial begin
    p = PINS_RESET;
    smp = '0;
    tick(3);
    rst = 1'b0;
    tick(1);
    check(channel_power === 8'hff && rdy_n === 1'b1, "reset");
    tick(WAKE_CYC);
    convert(8'hff, 1'b0, 1'b0);
    m = 8'hff;
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < N_CH; j++) smp[j] = RES_W'($random(seed));
      if (i > 0) begin
        m = (i == 1) ? 8'h80 : (8'($random(seed)) | 8'h01);
        write_cfg(m);
        p.idle_channel_powerdown_n = 1'b0;
        tick(6);
        check(channel_power === m, "idle power");
        p.idle_channel_powerdown_n = 1'b1;
      end
      // A start that the next strobe fall abandons.
      if (i == 3) begin
        p.sample_start_strobe = 1'b0;
        tick(6);
        p.sample_start_strobe = 1'b1;
        tick(12);
        check(hold === 1'b1 && rdy_n === 1'b1, "start held");
        // Fresh codes show whether the restart really sampled again.
        for (int j = 0; j < N_CH; j++) smp[j] = ~smp[j];
      end
      convert(m, i inside {1, 2}, 1'b0);
      read_all(m, i[0]);
      p.cs_n = 1'b1;
    end
    p.full_power_down = 1'b1;
    tick(6);
    check(last_n === 1'b1 && rdy_n === 1'b1, "down");
    check(apwr === 1'b0 && channel_power === 8'h00, "power off");
    p.cs_n = 1'b0;
    p.rd_n = 1'b0;
    tick(6);
    check(data_oe === 1'b1, "read in shutdown");
    p.rd_n = 1'b1;
    p.cs_n = 1'b1;
    tick(6);
    convert(m, 1'b0, 1'b1);
    summarize();
  end
  initial begin
    #1500000;
    check(1'b0, "timeout");
    summarize();
  end
endmodule : test_adc_seq
